//--- design/pccl_top.sv
// paired-channel call logic of a four-channel loop detector
// assumes occupancy, timed calls and loop fail come from core-clock logic;
// phase green pins are asynchronous and active low
`timescale 1ns/100ps
`default_nettype none
`include "pccl_defines.svh"

module pccl_top #(
  parameter logic [35:0] P_AUD_TMO_CYC = 36'(`PCCL_AUD_CYC) // audible timeout
) (
  input  wire logic        i_core_clk,       // 40 MHz clock
  input  wire logic        i_sys_rst,        // sync reset, high
  input  wire logic        i_awvalid,        // write address valid
  output logic             o_awready,        // write address ready
  input  wire logic [7:0]  i_awaddr,         // write byte address
  input  wire logic        i_wvalid,         // write data valid
  output logic             o_wready,         // write data ready
  input  wire logic [31:0] i_wdata,          // write data
  input  wire logic [3:0]  i_wstrb,          // byte strobes
  output logic             o_bvalid,         // write response valid
  input  wire logic        i_bready,         // write response ready
  output logic [1:0]       o_bresp,          // write response
  input  wire logic        i_arvalid,        // read address valid
  output logic             o_arready,        // read address ready
  input  wire logic [7:0]  i_araddr,         // read byte address
  output logic             o_rvalid,         // read data valid
  input  wire logic        i_rready,         // read data ready
  output logic [31:0]      o_rdata,          // read data
  output logic [1:0]       o_rresp,          // read response
  input  wire logic [3:0]  i_occ,            // loop occupied per channel
  input  wire logic [3:0]  i_chan_call,      // timed call per channel
  input  wire logic [3:0]  i_loop_fail,      // loop failed per channel
  input  wire logic [3:0]  i_phase_green_n,  // phase green pins, low
  output logic [3:0]       o_call,           // call to controller
  output logic [3:0]       o_pending,        // pending indication
  output logic [3:0]       o_presence_force, // stop timers, presence
  output logic             o_filter_bypass,  // skip noise filter
  output logic             o_chan_rst,       // reset all channels
  output logic [3:0]       o_desens_en,      // desensitise loop
  output logic [15:0]      o_desens_max_ppm, // desens cap, ppm
  output logic             o_audible         // audible signal
);

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  ////////////////////////////////////////////////////////////////////////
  // phase green pins
  logic [3:0] pg_s1_r;
  logic [3:0] pg_s2_r;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pg_s1_r <= `PCCL_PG_RST;
      pg_s2_r <= `PCCL_PG_RST;
    end else begin
      pg_s1_r <= i_phase_green_n;
      pg_s2_r <= pg_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write channels
  logic        aw_rdy_r;
  logic        w_rdy_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        wr_go;
  logic        wr_lo;
  logic        b_done;

  function automatic logic addr_ok(input logic [7:0] a);
    logic [7:0] w;
    w = a & `PCCL_A_MASK;
    return (w == `PCCL_A_CTRL) || (w == `PCCL_A_CFG) ||
           (w == `PCCL_A_CMD) || (w == `PCCL_A_STAT);
  endfunction

  assign wr_go  = ~aw_rdy_r & ~w_rdy_r & ~bvalid_r;
  assign wr_lo  = wr_go & w_strb_r[0];
  assign b_done = bvalid_r & i_bready;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      aw_rdy_r  <= 1'b1;
      aw_addr_r <= 8'h00;
    end else if (i_awvalid && aw_rdy_r) begin
      aw_rdy_r  <= 1'b0;
      aw_addr_r <= i_awaddr & `PCCL_A_MASK;
    end else if (b_done) begin
      aw_rdy_r  <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      w_rdy_r  <= 1'b1;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (i_wvalid && w_rdy_r) begin
      w_rdy_r  <= 1'b0;
      w_data_r <= i_wdata;
      w_strb_r <= i_wstrb;
    end else if (b_done) begin
      w_rdy_r  <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `PCCL_RESP_OK;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= addr_ok(aw_addr_r) ? `PCCL_RESP_OK : `PCCL_RESP_ERR;
    end else if (b_done) begin
      bvalid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // global filter bypass
  logic byp_r;
  logic chan_rst_r;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      byp_r      <= `PCCL_BYP_RST;
      chan_rst_r <= 1'b0;
    end else begin
      chan_rst_r <= 1'b0;
      if (wr_lo && aw_addr_r == `PCCL_A_CTRL) begin
        byp_r      <= w_data_r[`PCCL_CTRL_BYP];
        // restarts channel timing only; fail count and fail display live
        // in the channel fault logic, which this pulse does not reach
        chan_rst_r <= w_data_r[`PCCL_CTRL_BYP] != byp_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-channel option commands
  logic       cmd_go;
  logic [1:0] cmd_ch;
  logic [1:0] cmd_opt;
  logic       cmd_val;

  assign cmd_go  = wr_lo && aw_addr_r == `PCCL_A_CMD;
  assign cmd_ch  = w_data_r[`PCCL_CMD_CH];
  assign cmd_opt = w_data_r[`PCCL_CMD_OPT];
  assign cmd_val = w_data_r[`PCCL_CMD_VAL];

  // one mode per pair: channel bit 1 picks the pair, so both channels
  // share it and the two pair options cannot both be on
  pccl_pkg::pccl_mode_t mode_r [2];

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      mode_r[0] <= pccl_pkg::PCCL_MODE_OFF;
      mode_r[1] <= pccl_pkg::PCCL_MODE_OFF;
    end else if (cmd_go && cmd_opt == `PCCL_OPT_AND) begin
      if (cmd_val) begin
        mode_r[cmd_ch[1]] <= pccl_pkg::PCCL_MODE_AND;
      end else if (mode_r[cmd_ch[1]] == pccl_pkg::PCCL_MODE_AND) begin
        mode_r[cmd_ch[1]] <= pccl_pkg::PCCL_MODE_OFF;
      end
    end else if (cmd_go && cmd_opt == `PCCL_OPT_DIR) begin
      if (cmd_val) begin
        mode_r[cmd_ch[1]] <= pccl_pkg::PCCL_MODE_DIR;
      end else if (mode_r[cmd_ch[1]] == pccl_pkg::PCCL_MODE_DIR) begin
        mode_r[cmd_ch[1]] <= pccl_pkg::PCCL_MODE_OFF;
      end
    end
  end

  logic [3:0] gcomp_r;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      gcomp_r <= 4'h0;
    end else if (cmd_go && cmd_opt == `PCCL_OPT_GC) begin
      gcomp_r[cmd_ch] <= cmd_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // audible option and its timeout
  logic [3:0]  aud_r;
  logic [35:0] aud_tmr_r;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      aud_r     <= 4'h0;
      aud_tmr_r <= 36'h0_0000_0000;
    end else if (cmd_go && cmd_opt == `PCCL_OPT_AUD && cmd_val) begin
      aud_r     <= 4'h1 << cmd_ch;
      aud_tmr_r <= 36'h0_0000_0000;
    end else if (cmd_go && cmd_opt == `PCCL_OPT_AUD) begin
      aud_r[cmd_ch] <= 1'b0;
    end else if (|aud_r) begin
      if (aud_tmr_r == P_AUD_TMO_CYC - 36'h0_0000_0001) begin
        aud_r     <= 4'h0;
        aud_tmr_r <= 36'h0_0000_0000;
      end else begin
        aud_tmr_r <= aud_tmr_r + 36'h0_0000_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pair state: first and later detector per channel
  logic [3:0] is_and;
  logic [3:0] is_dir;
  logic [3:0] pfail;
  logic [3:0] first_r;
  logic [3:0] later_r;
  logic [3:0] first_nxt;
  logic [3:0] later_nxt;
  logic [3:0] call_nxt;
  logic [3:0] pend_nxt;

  always_comb begin
    for (int c = 0; c < 4; c++) begin
      is_and[c] = mode_r[c / 2] == pccl_pkg::PCCL_MODE_AND;
      is_dir[c] = mode_r[c / 2] == pccl_pkg::PCCL_MODE_DIR;
      pfail[c]  = i_loop_fail[c] | i_loop_fail[c ^ 1];
    end
  end

  always_comb begin
    for (int c = 0; c < 4; c++) begin
      // arrival in the same cycle on both: the lower channel counts first
      first_nxt[c] = is_dir[c] & i_occ[c] & (first_r[c] |
                     (~first_r[c ^ 1] & ~later_r[c ^ 1] & ~later_r[c] &
                      (~i_occ[c ^ 1] | ~c[0])));
      later_nxt[c] = is_dir[c] & i_occ[c] &
                     (later_r[c] | first_r[c ^ 1]);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      first_r <= 4'h0;
      later_r <= 4'h0;
    end else begin
      first_r <= first_nxt;
      later_r <= later_nxt;
    end
  end

  always_comb begin
    for (int c = 0; c < 4; c++) begin
      if (is_and[c]) begin
        call_nxt[c] = (i_occ[c] & i_occ[c ^ 1]) | pfail[c];
        pend_nxt[c] = i_occ[c] & ~i_occ[c ^ 1];
      end else if (is_dir[c]) begin
        call_nxt[c] = later_r[c] | pfail[c];
        pend_nxt[c] = first_r[c];
      end else begin
        call_nxt[c] = i_chan_call[c];
        pend_nxt[c] = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs
  logic [3:0]  call_r;
  logic [3:0]  pend_r;
  logic [3:0]  pres_r;
  logic [3:0]  desens_r;
  logic [15:0] desens_max_r;
  logic        audible_r;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      call_r <= 4'h0;
      pend_r <= 4'h0;
      pres_r <= 4'h0;
    end else begin
      call_r <= call_nxt;
      pend_r <= pend_nxt;
      pres_r <= first_r & is_dir;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      desens_r     <= 4'h0;
      desens_max_r <= 16'h0000;
      audible_r    <= 1'b0;
    end else begin
      desens_r     <= gcomp_r & ~pg_s2_r;
      desens_max_r <= `PCCL_DESENS_PPM;
      audible_r    <= |(aud_r & i_occ);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel
  logic        ar_rdy_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [31:0] rd_mux;
  logic [3:0]  and_bits;
  logic [3:0]  dir_bits;

  assign and_bits = is_and;
  assign dir_bits = is_dir;

  always_comb begin
    unique case (i_araddr & `PCCL_A_MASK)
      `PCCL_A_CTRL: rd_mux = {31'h0000_0000, byp_r};
      `PCCL_A_CFG:  rd_mux = {16'h0000, gcomp_r, aud_r, dir_bits, and_bits};
      `PCCL_A_STAT: rd_mux = {14'h0000, audible_r, byp_r,
                              desens_r, call_r, pend_r, i_occ};
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      ar_rdy_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `PCCL_RESP_OK;
    end else if (i_arvalid && ar_rdy_r) begin
      ar_rdy_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= addr_ok(i_araddr) ? `PCCL_RESP_OK : `PCCL_RESP_ERR;
    end else if (rvalid_r && i_rready) begin
      ar_rdy_r <= 1'b1;
      rvalid_r <= 1'b0;
    end
  end

  assign o_awready        = aw_rdy_r;
  assign o_wready         = w_rdy_r;
  assign o_bvalid         = bvalid_r;
  assign o_bresp          = bresp_r;
  assign o_arready        = ar_rdy_r;
  assign o_rvalid         = rvalid_r;
  assign o_rdata          = rdata_r;
  assign o_rresp          = rresp_r;
  assign o_call           = call_r;
  assign o_pending        = pend_r;
  assign o_presence_force = pres_r;
  assign o_filter_bypass  = byp_r;
  assign o_chan_rst       = chan_rst_r;
  assign o_desens_en      = desens_r;
  assign o_desens_max_ppm = desens_max_r;
  assign o_audible        = audible_r;

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_byp_rst;
    $changed(byp_r) |-> o_chan_rst ##1 !o_chan_rst;
  endproperty
  a_byp_rst: assert property (p_byp_rst)
    else $error("bypass change without one channel reset pulse");

  property p_rst_cause;
    o_chan_rst |-> $changed(o_filter_bypass);
  endproperty
  a_rst_cause: assert property (p_rst_cause)
    else $error("channel reset without bypass change");

  property p_desens;
    o_desens_en == $past(gcomp_r & ~pg_s2_r);
  endproperty
  a_desens: assert property (p_desens)
    else $error("desensitise not tied to green and option");

  property p_desens_cap;
    $past(!i_sys_rst) |-> o_desens_max_ppm == `PCCL_DESENS_PPM;
  endproperty
  a_desens_cap: assert property (p_desens_cap)
    else $error("desensitise cap wrong");

  property p_and_call;
    $past(mode_r[0] == pccl_pkg::PCCL_MODE_AND && i_loop_fail[1:0] == 2'h0)
      |-> o_call[1:0] == {2{$past(&i_occ[1:0])}};
  endproperty
  a_and_call: assert property (p_and_call)
    else $error("and pairing call mismatch");

  property p_and_pend;
    mode_r[0] == pccl_pkg::PCCL_MODE_AND && i_occ[0] && !i_occ[1] && !pfail[0]
      |=> o_pending[0] && !o_call[0];
  endproperty
  a_and_pend: assert property (p_and_pend)
    else $error("and pairing pending missing");

  property p_dir_first;
    first_r[2] && is_dir[2] && !pfail[2] |=> !o_call[2] && o_pending[2];
  endproperty
  a_dir_first: assert property (p_dir_first)
    else $error("first directional channel called");

  sequence s_dir_late;
    is_dir[3] && later_r[3] && i_occ[3];
  endsequence
  sequence s_call_held;
    o_call[3] ##1 (o_call[3] || !$past(i_occ[3]));
  endsequence
  property p_dir_late;
    s_dir_late |=> s_call_held;
  endproperty
  a_dir_late: assert property (p_dir_late)
    else $error("later directional channel dropped call early");

  property p_dir_excl;
    $past(is_dir[2] && !pfail[2]) && $past(is_dir[2], 2)
      |-> o_call[3:2] != 2'h3;
  endproperty
  a_dir_excl: assert property (p_dir_excl)
    else $error("both directional outputs on without failure");

  property p_dir_fail;
    is_dir[2] && pfail[2] |=> o_call[3:2] == 2'h3;
  endproperty
  a_dir_fail: assert property (p_dir_fail)
    else $error("loop failure did not force both calls");

  property p_aud_one;
    $onehot0(aud_r) && aud_tmr_r < P_AUD_TMO_CYC;
  endproperty
  a_aud_one: assert property (p_aud_one)
    else $error("audible on several channels or timer overrun");

  property p_aud_sig;
    o_audible == $past(|(aud_r & i_occ));
  endproperty
  a_aud_sig: assert property (p_aud_sig)
    else $error("audible not following occupancy");

  property p_aud_tmo;
    (|aud_r) && aud_tmr_r == P_AUD_TMO_CYC - 36'h0_0000_0001 && !cmd_go
      |=> aud_r == 4'h0;
  endproperty
  a_aud_tmo: assert property (p_aud_tmo)
    else $error("audible option outlived its timeout");

endmodule
`default_nettype wire

//--- design/pccl_defines.svh
// register map, field positions and timing counts of the pair logic
// assumes a 40 MHz core clock and AXI4-Lite byte addresses
`ifndef PCCL_DEFINES_SVH
`define PCCL_DEFINES_SVH
`define PCCL_A_CTRL     8'h00
`define PCCL_A_CFG      8'h04
`define PCCL_A_CMD      8'h08
`define PCCL_A_STAT     8'h0C
`define PCCL_A_MASK     8'hFC
`define PCCL_CTRL_BYP   0
`define PCCL_CMD_CH     1:0
`define PCCL_CMD_OPT    3:2
`define PCCL_CMD_VAL    4
`define PCCL_OPT_AND    2'h0
`define PCCL_OPT_DIR    2'h1
`define PCCL_OPT_AUD    2'h2
`define PCCL_OPT_GC     2'h3
`define PCCL_BYP_RST    1'b0
`define PCCL_PG_RST     4'hF
`define PCCL_RESP_OK    2'h0
`define PCCL_RESP_ERR   2'h2
`define PCCL_CLK_HZ     64'd40000000
`define PCCL_AUD_MIN    64'd15
`define PCCL_AUD_CYC    (`PCCL_AUD_MIN * 64'd60 * `PCCL_CLK_HZ)
// 0.05 % of loop inductance, in parts per million
`define PCCL_DESENS_PPM 16'h01F4
`endif

//--- design/pccl_pkg.sv
// types shared by the pair logic
// assumes nothing of its surroundings
package pccl_pkg;
  typedef enum logic [1:0] {
    PCCL_MODE_OFF,
    PCCL_MODE_AND,
    PCCL_MODE_DIR
  } pccl_mode_t;
endpackage

//--- dv/pccl_ctrl_model.sv
// controller stand-in: drives the phase green pins, watches the calls
// assumes the bench asks for green phases through i_green
`timescale 1ns/100ps
`default_nettype none
module pccl_ctrl_model (
  input  wire logic       i_core_clk,      // core clock
  input  wire logic       i_sys_rst,       // sync reset, high
  input  wire logic [3:0] i_green,         // green wanted per phase
  input  wire logic [3:0] i_call,          // calls from detector
  output logic      [3:0] o_phase_green_n, // green pins, low active
  output logic      [3:0] o_served         // call seen during green
);
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_phase_green_n <= 4'hF;
      o_served        <= 4'h0;
    end else begin
      o_phase_green_n <= ~i_green;
      o_served        <= i_call & i_green;
    end
  end
endmodule
`default_nettype wire

//--- dv/tb_paired_channel_call_logic.sv
// self-checking bench of the paired-channel call logic
// assumes the controller model drives the green pins
`timescale 1ns/100ps
`default_nettype none
`include "pccl_defines.svh"
module tb_paired_channel_call_logic;
  logic        i_core_clk, i_sys_rst, i_awvalid, i_wvalid, i_bready;
  logic        i_arvalid, i_rready;
  logic [7:0]  i_awaddr, i_araddr;
  logic [31:0] i_wdata;
  logic [3:0]  i_wstrb, i_occ, i_chan_call, i_loop_fail, green;
  wire  [3:0]  i_phase_green_n, o_call, o_pending, o_presence_force, o_desens_en, served;
  wire         o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  wire         o_filter_bypass, o_chan_rst, o_audible;
  wire  [1:0]  o_bresp, o_rresp;
  wire  [31:0] o_rdata;
  wire  [15:0] o_desens_max_ppm;
  int          fail_count, checks, seed, cyc, rst_seen;

  pccl_top #(.P_AUD_TMO_CYC(36'd50)) dut_u (
    .i_core_clk, .i_sys_rst, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid,
    .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid,
    .o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp, .i_occ,
    .i_chan_call, .i_loop_fail, .i_phase_green_n, .o_call, .o_pending,
    .o_presence_force, .o_filter_bypass, .o_chan_rst, .o_desens_en,
    .o_desens_max_ppm, .o_audible);

  pccl_ctrl_model ctrl_u (
    .i_core_clk, .i_sys_rst, .i_green(green), .i_call(o_call),
    .o_phase_green_n(i_phase_green_n), .o_served(served));

  always #12.5 i_core_clk = ~i_core_clk;

  always @(posedge i_core_clk) begin
    cyc++;
    if (o_chan_rst === 1'b1) rst_seen++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask

  // waits end on the answer; the cycle ceiling cuts a hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit done;
    done = 0;
    i_awvalid <= 1'b1;
    i_wvalid  <= 1'b1;
    i_awaddr  <= a;
    i_wdata   <= d;
    i_bready  <= 1'b1;
    while (!done) begin
      @(posedge i_core_clk);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      if (o_bvalid === 1'b1) begin
        chk(32'(o_bresp), 32'(er));
        done = 1;
      end
    end
    i_bready <= 1'b0;
    @(posedge i_core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit done;
    done = 0;
    i_arvalid <= 1'b1;
    i_araddr  <= a;
    i_rready  <= 1'b1;
    while (!done) begin
      @(posedge i_core_clk);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      if (o_rvalid === 1'b1) begin
        chk(o_rdata, ed);
        chk(32'(o_rresp), 32'(er));
        done = 1;
      end
    end
    i_rready <= 1'b0;
    @(posedge i_core_clk);
  endtask

  task automatic opt(input logic [1:0] ch, input logic [1:0] o, input logic on);
    wr(`PCCL_A_CMD, {27'h0, on, o, ch}, `PCCL_RESP_OK);
  endtask

  // AND on pair 0, plain timed calls on pair 1
  function automatic logic [3:0] f_and(input logic [3:0] occ, input logic [3:0] cc);
    f_and = {cc[3:2], {2{occ[0] & occ[1]}}};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  initial begin
    i_core_clk = 0;
    i_sys_rst = 1;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
    i_awaddr = 8'h00;
    i_araddr = 8'h00;
    i_wdata = 32'h0000_0000;
    i_wstrb = 4'hF;
    {i_occ, i_chan_call, i_loop_fail, green} = '0;
    seed = 18;
    repeat (2) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    step(3);
    chk(32'(o_filter_bypass), 32'h0000_0000);
    chk(32'(o_desens_max_ppm), 32'(`PCCL_DESENS_PPM));
    rd(`PCCL_A_CTRL, 32'h0000_0000, `PCCL_RESP_OK);
    // bypass: one global bit, every real change pulses the channel reset
    wr(`PCCL_A_CTRL, 32'h0000_0001, `PCCL_RESP_OK);
    step(2);
    chk(32'(rst_seen), 32'h0000_0001);
    chk(32'(o_filter_bypass), 32'h0000_0001);
    rd(`PCCL_A_STAT, 32'h0001_0000, `PCCL_RESP_OK);
    wr(`PCCL_A_CTRL, 32'h0000_0001, `PCCL_RESP_OK);
    wr(`PCCL_A_CTRL, 32'h0000_0000, `PCCL_RESP_OK);
    step(2);
    chk(32'(rst_seen), 32'h0000_0002);
    // a write without the low byte strobe must leave bypass alone
    i_wstrb <= 4'hE;
    wr(`PCCL_A_CTRL, 32'h0000_0001, `PCCL_RESP_OK);
    i_wstrb <= 4'hF;
    step(2);
    chk(32'(o_filter_bypass), 32'h0000_0000);
    chk(32'(rst_seen), 32'h0000_0002);
    wr(8'h40, 32'h0000_0001, `PCCL_RESP_ERR);
    rd(8'h40, 32'h0000_0000, `PCCL_RESP_ERR);
    rd(`PCCL_A_CMD, 32'h0000_0000, `PCCL_RESP_OK);
    // pair options follow the partner and exclude each other
    opt(2'd0, `PCCL_OPT_AND, 1'b1);
    rd(`PCCL_A_CFG, 32'h0000_0003, `PCCL_RESP_OK);
    opt(2'd1, `PCCL_OPT_DIR, 1'b1);
    rd(`PCCL_A_CFG, 32'h0000_0030, `PCCL_RESP_OK);
    opt(2'd1, `PCCL_OPT_AND, 1'b1);
    rd(`PCCL_A_CFG, 32'h0000_0003, `PCCL_RESP_OK);
    for (int k = 0; k < 40; k++) begin
      i_occ <= 4'($random(seed));
      i_chan_call <= 4'($random(seed));
      step(3);
      chk(32'(o_call), 32'(f_and(i_occ, i_chan_call)));
      chk(32'(o_pending[1:0]), 32'(i_occ[1:0] & ~{i_occ[0], i_occ[1]}));
    end
    // directional on pair 1: channel 2 arrives first
    i_occ <= 4'h0;
    i_chan_call <= 4'h0;
    opt(2'd2, `PCCL_OPT_DIR, 1'b1);
    rd(`PCCL_A_CFG, 32'h0000_00C3, `PCCL_RESP_OK);
    i_occ <= 4'b0100;
    step(4);
    chk(32'(o_call[3:2]), 32'h0000_0000);
    chk(32'(o_pending[3:2]), 32'h0000_0001);
    chk(32'(o_presence_force[3:2]), 32'h0000_0001);
    i_occ <= 4'b1100;
    step(4);
    chk(32'(o_call[3:2]), 32'h0000_0002);
    i_occ <= 4'b1000;
    step(4);
    chk(32'(o_call[3:2]), 32'h0000_0002);
    i_occ <= 4'b0000;
    step(4);
    chk(32'(o_call[3:2]), 32'h0000_0000);
    i_loop_fail <= 4'b0100;
    step(4);
    chk(32'(o_call[3:2]), 32'h0000_0003);
    i_loop_fail <= 4'b0000;
    step(4);
    chk(32'(o_call[3:2]), 32'h0000_0000);
    // audible: single owner, raw occupancy, self timeout restarted
    opt(2'd1, `PCCL_OPT_AUD, 1'b1);
    step(30);
    opt(2'd0, `PCCL_OPT_AUD, 1'b1);
    rd(`PCCL_A_CFG, 32'h0000_01C3, `PCCL_RESP_OK);
    i_occ <= 4'b0001;
    i_chan_call <= 4'b0000;
    step(3);
    chk(32'(o_audible), 32'h0000_0001);
    step(18);
    chk(32'(o_audible), 32'h0000_0001);
    step(30);
    chk(32'(o_audible), 32'h0000_0000);
    rd(`PCCL_A_CFG, 32'h0000_00C3, `PCCL_RESP_OK);
    i_occ <= 4'b0000;
    // green compensation on channel 0 only
    opt(2'd0, `PCCL_OPT_GC, 1'b1);
    step(5);
    chk(32'(o_desens_en), 32'h0000_0000);
    green <= 4'b0011;
    step(6);
    chk(32'(o_desens_en), 32'h0000_0001);
    i_occ <= 4'b0011;
    step(4);
    chk(32'(served), 32'h0000_0003);
    i_occ <= 4'b0000;
    opt(2'd0, `PCCL_OPT_GC, 1'b0);
    step(3);
    chk(32'(o_desens_en), 32'h0000_0000);
    // an off command clears only the option in force, from either channel
    opt(2'd0, `PCCL_OPT_DIR, 1'b0);
    opt(2'd3, `PCCL_OPT_DIR, 1'b0);
    rd(`PCCL_A_CFG, 32'h0000_0003, `PCCL_RESP_OK);
    // power loss: a mid-run reset drops bypass and the audible option
    wr(`PCCL_A_CTRL, 32'h0000_0001, `PCCL_RESP_OK);
    opt(2'd2, `PCCL_OPT_AUD, 1'b1);
    i_sys_rst <= 1'b1;
    step(2);
    i_sys_rst <= 1'b0;
    step(2);
    rd(`PCCL_A_CTRL, 32'h0000_0000, `PCCL_RESP_OK);
    rd(`PCCL_A_CFG, 32'h0000_0000, `PCCL_RESP_OK);
    results();
  end
endmodule
`default_nettype wire
